// ===== hw/intc_pm.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
module intc_pm #(
  parameter int STAB_CYCLES = intc_pkg::HALT_STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] ext_int_pins_i,
  input wire logic [6:0] periph_flag_set_i,
  input wire logic [6:0] assoc_access_i,
  input wire logic instr_boundary_i,
  output logic global_int_mask_o,
  output logic osc_run_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic cpu_hold_o,
  output logic int_entry_o,
  output logic [15:0] vector_o,
  output logic [15:0] sp_o
);
  if (STAB_CYCLES < 1) begin : g_bad_stab
    $error("stab cycles must be positive");
  end
  localparam int SW = $clog2(STAB_CYCLES + 1);

  // ****************************************
  // bus decode
  // ****************************************
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;

  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] r);
    is_addr = (a == r);
  endfunction

  assign mapped = is_addr(paddr_i, intc_pkg::EXT_INT_ENABLE_REG_ADDR) | is_addr(paddr_i, intc_pkg::CTRL_REG_ADDR)
    | is_addr(paddr_i, intc_pkg::STATUS_REG_ADDR) | is_addr(paddr_i, intc_pkg::PERIPH_EN_REG_ADDR)
    | is_addr(paddr_i, intc_pkg::PERIPH_FLAG_REG_ADDR) | is_addr(paddr_i, intc_pkg::VECTOR_REG_ADDR)
    | is_addr(paddr_i, intc_pkg::CMD_REG_ADDR);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ext_int_enable_r;
  logic sms_r;
  logic [6:0] periph_en_r;
  logic mask_r;
  intc_pkg::pm_state_t state_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_int_enable_r <= intc_pkg::EXT_INT_ENABLE_RESET;
    end else if (wr_en && is_addr(paddr_i, intc_pkg::EXT_INT_ENABLE_REG_ADDR)) begin
      ext_int_enable_r <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sms_r <= 1'b0;
    end else if (wr_en && is_addr(paddr_i, intc_pkg::CTRL_REG_ADDR)) begin
      sms_r <= pwdata_i[intc_pkg::CTRL_SMS_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periph_en_r <= '0;
    end else if (wr_en && is_addr(paddr_i, intc_pkg::PERIPH_EN_REG_ADDR)) begin
      periph_en_r <= pwdata_i[6:0];
    end
  end

  logic [2:0] cmd;
  assign cmd = (wr_en && is_addr(paddr_i, intc_pkg::CMD_REG_ADDR)) ? pwdata_i[2:0] : intc_pkg::CMD_NONE;

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_d_r;
  wire [7:0] pin_edge;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r <= '0;
    end else begin
      pin_s1_r <= ext_int_pins_i;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      if (intc_pkg::RISING_MASK[gi]) begin : g_rise
        assign pin_edge[gi] = pin_s2_r[gi] & ~pin_d_r[gi];
      end else begin : g_fall
        assign pin_edge[gi] = ~pin_s2_r[gi] & pin_d_r[gi];
      end
    end
  endgenerate

  // ****************************************
  // request latches
  // ****************************************
  logic ext_pend_r;
  logic [6:0] flag_r;
  logic [6:0] armed_r;
  logic [6:0] clr_zero;
  logic [6:0] clr_seq;
  logic flag_rd;
  logic take;
  logic [2:0] sel_r;
  assign flag_rd = (rd_en | wr_en) && is_addr(paddr_i, intc_pkg::PERIPH_FLAG_REG_ADDR);
  assign clr_zero = (wr_en && is_addr(paddr_i, intc_pkg::PERIPH_FLAG_REG_ADDR)) ? ~pwdata_i[6:0] : 7'h00;
  assign clr_seq = armed_r & assoc_access_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_r <= '0;
    end else if (flag_rd) begin
      armed_r <= flag_r;
    end else begin
      armed_r <= armed_r & ~assoc_access_i;
    end
  end

  // set wins over clear; clear discards latched request
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~(clr_zero | clr_seq)) | periph_flag_set_i;
    end
  end

  // pin edges latch only when enabled and mask clear or halted
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_pend_r <= 1'b0;
    end else if (|(pin_edge & ext_int_enable_r) && (!mask_r || state_r == intc_pkg::ST_HALT)) begin
      ext_pend_r <= 1'b1;
    end else if (take && sel_r == 3'(intc_pkg::SRC_EXT)) begin
      ext_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // priority
  // ****************************************
  logic [7:0] req;
  logic [7:0] enabled;
  logic trap_r;
  assign req = {flag_r[6:3], ext_pend_r, flag_r[2:1], trap_r};
  assign enabled = req & {periph_en_r[6:3], 1'b1, periph_en_r[2:1], 1'b1};

  function automatic logic [2:0] pick(input logic [7:0] r);
    pick = 3'd0;
    for (int i = intc_pkg::NSRC - 1; i >= 0; i--) begin
      if (r[i]) pick = 3'(i);
    end
  endfunction

  logic svc_ok;
  logic [7:0] servable;
  assign servable = mask_r ? (enabled & 8'h01) : enabled;
  assign svc_ok = |servable;

  // ****************************************
  // sequencer
  // ****************************************
  logic [SW-1:0] stab_r;
  logic [2:0] push_r;
  logic from_reset_r;
  assign take = (state_r == intc_pkg::ST_VECT);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trap_r <= 1'b0;
    end else if (cmd == intc_pkg::CMD_TRAP) begin
      trap_r <= 1'b1;
    end else if (take && sel_r == 3'(intc_pkg::SRC_TRAP)) begin
      trap_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= intc_pkg::ST_RUN;
      sel_r <= '0;
      stab_r <= '0;
      push_r <= '0;
      from_reset_r <= 1'b1;
    end else begin
      unique case (state_r)
        intc_pkg::ST_RUN: begin
          if (cmd == intc_pkg::CMD_HALT) begin
            state_r <= intc_pkg::ST_HALT;
          end else if (cmd == intc_pkg::CMD_WFI) begin
            state_r <= intc_pkg::ST_WAIT;
          end else if (cmd == intc_pkg::CMD_INTERRUPT_RETURN) begin
            state_r <= intc_pkg::ST_POP;
            push_r <= '0;
          end else if (instr_boundary_i && svc_ok) begin
            sel_r <= pick(servable);
            push_r <= '0;
            state_r <= intc_pkg::ST_PUSH;
          end
        end
        intc_pkg::ST_PUSH: begin
          push_r <= push_r + 3'd1;
          if (push_r == 3'(intc_pkg::CONTEXT_BYTES - 1)) state_r <= intc_pkg::ST_VECT;
        end
        intc_pkg::ST_VECT: begin
          from_reset_r <= 1'b0;
          state_r <= intc_pkg::ST_RUN;
        end
        intc_pkg::ST_POP: begin
          push_r <= push_r + 3'd1;
          if (push_r == 3'(intc_pkg::CONTEXT_BYTES - 1)) state_r <= intc_pkg::ST_RUN;
        end
        intc_pkg::ST_WAIT: begin
          if (|enabled) begin
            sel_r <= pick(enabled);
            push_r <= '0;
            state_r <= intc_pkg::ST_PUSH;
          end
        end
        intc_pkg::ST_HALT: begin
          if (|(enabled & intc_pkg::HALT_WAKE_MASK)) begin
            sel_r <= pick(enabled & intc_pkg::HALT_WAKE_MASK);
            stab_r <= SW'(STAB_CYCLES - 1);
            state_r <= intc_pkg::ST_STAB;
          end
        end
        intc_pkg::ST_STAB: begin
          if (stab_r == '0) begin
            push_r <= '0;
            state_r <= intc_pkg::ST_PUSH;
          end else begin
            stab_r <= stab_r - SW'(1);
          end
        end
        default: state_r <= intc_pkg::ST_RUN;
      endcase
    end
  end

  // ****************************************
  // mask, stack pointer, vector
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_r <= 1'b1;
    end else if (state_r == intc_pkg::ST_VECT) begin
      mask_r <= 1'b1;
    end else if (state_r == intc_pkg::ST_POP && push_r == 3'(intc_pkg::CONTEXT_BYTES - 1)) begin
      mask_r <= 1'b0;
    end else if (cmd == intc_pkg::CMD_HALT || cmd == intc_pkg::CMD_WFI || cmd == intc_pkg::CMD_RIM) begin
      mask_r <= 1'b0;
    end else if (cmd == intc_pkg::CMD_SIM) begin
      mask_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_o <= intc_pkg::SP_RESET;
    end else if (state_r == intc_pkg::ST_PUSH) begin
      sp_o <= sp_o - 16'h0001;
    end else if (state_r == intc_pkg::ST_POP) begin
      sp_o <= sp_o + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vector_o <= intc_pkg::RESET_VECTOR;
    end else if (take) begin
      vector_o <= intc_pkg::TRAP_VECTOR - (16'(sel_r) * intc_pkg::VECTOR_STEP);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_entry_o <= 1'b0;
    end else begin
      int_entry_o <= take;
    end
  end

  // ****************************************
  // clock divider and enables
  // ****************************************
  logic [2:0] div_r;
  logic [2:0] div_max;
  assign div_max = sms_r ? 3'(intc_pkg::OSC_DIV * intc_pkg::SLOW_DIV - 1) : 3'(intc_pkg::OSC_DIV - 1);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= '0;
    end else begin
      div_r <= (div_r >= div_max) ? 3'd0 : div_r + 3'd1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= (div_r == 3'd0) && state_r == intc_pkg::ST_RUN;
      periph_clk_en_o <= (div_r == 3'd0) && state_r != intc_pkg::ST_HALT && state_r != intc_pkg::ST_STAB;
    end
  end

  // ****************************************
  // mode and mask outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_run_o <= 1'b1;
      cpu_hold_o <= 1'b0;
    end else begin
      osc_run_o <= (state_r != intc_pkg::ST_HALT);
      cpu_hold_o <= (state_r != intc_pkg::ST_RUN);
    end
  end

  // mask shows set in the same cycle as the entry pulse
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      global_int_mask_o <= 1'b1;
    end else begin
      global_int_mask_o <= mask_r | take;
    end
  end

  // ****************************************
  // bus answers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= '0;
    end else begin
      prdata_o <= '0;
      if (psel_i && !penable_i && !pwrite_i) begin
        if (is_addr(paddr_i, intc_pkg::EXT_INT_ENABLE_REG_ADDR)) prdata_o <= {24'h0000_00, ext_int_enable_r};
        else if (is_addr(paddr_i, intc_pkg::CTRL_REG_ADDR)) prdata_o <= {31'h0000_0000, sms_r};
        else if (is_addr(paddr_i, intc_pkg::STATUS_REG_ADDR))
          prdata_o <= {24'h0000_00, 1'b0, state_r, ext_pend_r, trap_r, mask_r, from_reset_r};
        else if (is_addr(paddr_i, intc_pkg::PERIPH_EN_REG_ADDR)) prdata_o <= {25'h000_0000, periph_en_r};
        else if (is_addr(paddr_i, intc_pkg::PERIPH_FLAG_REG_ADDR)) prdata_o <= {25'h000_0000, flag_r};
        else if (is_addr(paddr_i, intc_pkg::VECTOR_REG_ADDR)) prdata_o <= {16'h0000, vector_o};
      end
    end
  end
endmodule // intc_pm

// ===== hw/intc_pkg.sv
// Summary of operation
// - on entry finish instruction, push pc, x, a, cc; set global_int_mask
// - after save, load pc from the serviced source vector
// - interrupt_return pops context, restoring cc and clearing the mask
// - maskable requests served only with mask clear; otherwise stay latched
// - fixed priority: reset, trap, flash, usb suspend, pins, timer, i2c, serial, usb
// - software_trap is served regardless of global_int_mask
// - any interrupt source wakes the processor from wait mode
// - only pins, usb end-suspend, flash and reset wake from halt
// - inputs 1,2,5,6 detect rising edges; 3,4,7,8 falling edges
// - pin edge raises interrupt only when enabled and mask clear
// - enable register: bit i enables input i+1, resets to zero, read/write
// - peripheral flag interrupts only with mask clear and enable set
// - request cleared by zero write or status access then associated access
// - clearing sequence resets the latch, discarding a disabled pending request
// - after reset run mode, clock is oscillator divided by three
// - halt instruction stops the oscillator and all activity
// - entering halt clears global_int_mask
// - halt wake restarts oscillator and holds cpu 4096 oscillator cycles
// - after halt delay serve the waking interrupt or the reset vector
// - slow_mode_select halves the cpu and peripheral clock
// - wait_for_interrupt stops cpu, peripherals run, mask forced zero
// - context save takes five stack bytes, pc low byte at first location
package intc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] EXT_INT_ENABLE_REG_ADDR = 16'h0008;
  localparam logic [15:0] CTRL_REG_ADDR = 16'h000C;
  localparam logic [15:0] STATUS_REG_ADDR = 16'h0010;
  localparam logic [15:0] PERIPH_EN_REG_ADDR = 16'h0014;
  localparam logic [15:0] PERIPH_FLAG_REG_ADDR = 16'h0018;
  localparam logic [15:0] VECTOR_REG_ADDR = 16'h001C;
  localparam logic [7:0] EXT_INT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] RISING_MASK = 8'h33;
  // ctrl bits
  localparam int CTRL_SMS_BIT = 0;
  // cpu command codes written to cmd register
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_HALT = 3'h1;
  localparam logic [2:0] CMD_WFI = 3'h2;
  localparam logic [2:0] CMD_TRAP = 3'h3;
  localparam logic [2:0] CMD_INTERRUPT_RETURN = 3'h4;
  localparam logic [2:0] CMD_SIM = 3'h5;
  localparam logic [2:0] CMD_RIM = 3'h6;
  localparam logic [15:0] CMD_REG_ADDR = 16'h0020;
  // ****************************************
  // source indices, high priority first
  // ****************************************
  localparam int NSRC = 8;
  localparam int SRC_TRAP = 0;
  localparam int SRC_FLASH = 1;
  localparam int SRC_USB_SUSP = 2;
  localparam int SRC_EXT = 3;
  localparam int SRC_TIMER = 4;
  localparam int SRC_I2C = 5;
  localparam int SRC_SERIAL = 6;
  localparam int SRC_USB = 7;
  localparam logic [7:0] HALT_WAKE_MASK = 8'h0E;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
  localparam logic [15:0] VECTOR_STEP = 16'h0002;
  // ****************************************
  // timing
  // ****************************************
  localparam int OSC_DIV = 3;
  localparam int SLOW_DIV = 2;
  localparam int HALT_STAB_CYCLES = 4096;
  localparam int CONTEXT_BYTES = 5;
  localparam logic [15:0] SP_RESET = 16'h017F;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_PUSH = 3'b001,
    ST_VECT = 3'b011,
    ST_POP = 3'b010,
    ST_WAIT = 3'b110,
    ST_HALT = 3'b111,
    ST_STAB = 3'b101
  } pm_state_t;
endpackage

// ===== tb/intc_pm_properties.sv
`timescale 1ns/1ps
module intc_pm_chk #(
  parameter int STAB_CYCLES = intc_pkg::HALT_STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic int_entry_o,
  input wire logic global_int_mask_o,
  input wire logic [15:0] vector_o,
  input wire logic [15:0] sp_o,
  input wire logic osc_run_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  chk_err_pulse: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_entry_mask: assert property (int_entry_o |-> global_int_mask_o)
    else $error("mask clear at entry");
  chk_entry_vector: assert property (int_entry_o |-> !vector_o[0] && vector_o >= 16'hFFEE && vector_o <= 16'hFFFC)
    else $error("vector out of map");
  chk_stack_five: assert property (int_entry_o |-> sp_o == $past(sp_o, 7) - 16'h0005
    || sp_o == $past(sp_o, 6) - 16'h0005)
    else $error("context not five bytes");
  chk_osc_stop: assert property (!osc_run_o |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clock while halted");
  chk_halt_unmask: assert property ($fell(osc_run_o) |-> !global_int_mask_o)
    else $error("mask set in halt");
  chk_div_three: assert property (cpu_clk_en_o |=> !cpu_clk_en_o [*2])
    else $error("cpu clock too fast");
  chk_stab_hold: assert property ($rose(osc_run_o) |-> !int_entry_o [*8])
    else $error("entry before stabilisation");
endmodule // intc_pm_chk
bind intc_pm intc_pm_chk #(.STAB_CYCLES(STAB_CYCLES)) chk_i (.sys_clk_i, .rstn_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .int_entry_o, .global_int_mask_o, .vector_o, .sp_o, .osc_run_o, .cpu_clk_en_o,
  .periph_clk_en_o);

// ===== tb/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic cpu_clk_en_i,
  input wire logic cpu_hold_i,
  input wire logic stall_i,
  output logic instr_boundary_o
);
  // ****************************************
  // instruction boundaries, one per unstalled cpu tick
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instr_boundary_o <= 1'b0;
    end else begin
      instr_boundary_o <= cpu_clk_en_i && !cpu_hold_i && !stall_i;
    end
  end
endmodule // cpu_model

// ===== tb/intc_pm_bench.sv
`timescale 1ns/1ps
module intc_pm_bench;
  localparam int STAB = 8;
  localparam logic [15:0] EXT = intc_pkg::EXT_INT_ENABLE_REG_ADDR;
  localparam logic [15:0] PEN = intc_pkg::PERIPH_EN_REG_ADDR;
  localparam logic [15:0] FLG = intc_pkg::PERIPH_FLAG_REG_ADDR;
  logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] pins = 8'hCC; // idle levels: rising-edge inputs low, falling-edge inputs high
  logic [6:0] flags = 7'h00, acc = 7'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mask, osc, cpu_en, hold, entry, bnd, er, pclk;
  logic [15:0] vec, sp, last;
  logic [7:0] b;
  int failures = 0, checks = 0, seed = 32'he80d_451b, hits = 0, h0, wc, n, off, j, g;
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) stall <= ~stall;
  always @(posedge sys_clk) if (entry === 1'b1) begin hits <= hits + 1; last <= vec; end
  intc_pm #(.STAB_CYCLES(STAB)) dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ext_int_pins_i(pins), .periph_flag_set_i(flags), .assoc_access_i(acc),
    .instr_boundary_i(bnd), .global_int_mask_o(mask), .osc_run_o(osc), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(pclk), .cpu_hold_o(hold), .int_entry_o(entry), .vector_o(vec), .sp_o(sp));
  cpu_model partner (.sys_clk_i(sys_clk), .rstn_i(rstn), .cpu_clk_en_i(cpu_en), .cpu_hold_i(hold),
    .stall_i(stall), .instr_boundary_o(bnd));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] vec_of(input int s);
    return intc_pkg::TRAP_VECTOR - intc_pkg::VECTOR_STEP * 16'(s);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bound(input int c, input int lim);
    if (c >= lim) begin failures++; wrap_up; end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
    bound(k, 50);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [2:0] c);
    apb(1'b1, intc_pkg::CMD_REG_ADDR, {29'd0, c});
  endtask
  task automatic wait_entry(input logic [15:0] v);
    wc = 0;
    while (hits == h0 && wc < 300) begin @(negedge sys_clk); wc++; end
    bound(wc, 300);
    chk({16'h0000, last}, {16'h0000, v});
    @(posedge sys_clk);
  endtask
  task automatic quiet(input int c);
    repeat (c) @(negedge sys_clk);
    chk(32'(hits - h0), 32'h0000_0000);
    @(posedge sys_clk);
  endtask
  task automatic wait_mask(input logic v);
    int c;
    c = 0;
    while (mask !== v && c < 40) begin @(negedge sys_clk); c++; end
    bound(c, 40);
    @(posedge sys_clk);
  endtask
  task automatic pulse_flag(input logic [6:0] f);
    flags <= f;
    @(posedge sys_clk);
    flags <= 7'h00;
    @(posedge sys_clk);
  endtask
  task automatic gap;
    int c;
    c = 0;
    while (cpu_en !== 1'b1 && c < 20) begin @(negedge sys_clk); c++; end
    g = 0;
    do begin @(negedge sys_clk); g++; end while (cpu_en !== 1'b1 && g < 20);
    bound(c, 20);
    bound(g, 20);
    @(posedge sys_clk);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, EXT, 32'h0000_0000); chk(rd, 32'h0000_0000);
    apb(1'b0, 16'h0004, 32'h0000_0000); chk({31'd0, er}, 32'h0000_0001);
    n = $random(seed);
    apb(1'b1, EXT, 32'(n)); apb(1'b0, EXT, 32'h0000_0000); chk(rd, {24'd0, n[7:0]});
    cmd(intc_pkg::CMD_RIM); wait_mask(1'b0);
    off = $random(seed) & 7;
    for (int i = 0; i < 8; i++) begin
      j = (i + off) % 8;
      b = 8'h01 << j;
      apb(1'b1, EXT, {24'd0, b});
      h0 = hits; pins[j] <= ~pins[j];
      wait_entry(vec_of(intc_pkg::SRC_EXT));
      chk({31'd0, mask}, 32'h0000_0001);
      cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_mask(1'b0);
      h0 = hits; pins[j] <= ~pins[j];
      quiet(30);
    end
    cmd(intc_pkg::CMD_SIM); wait_mask(1'b1);
    h0 = hits; cmd(intc_pkg::CMD_TRAP); wait_entry(vec_of(intc_pkg::SRC_TRAP));
    apb(1'b0, intc_pkg::VECTOR_REG_ADDR, 32'h0000_0000);
    chk(rd, {16'h0000, vec_of(intc_pkg::SRC_TRAP)});
    cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_mask(1'b0); cmd(intc_pkg::CMD_SIM); wait_mask(1'b1);
    apb(1'b1, PEN, 32'h0000_0028);
    h0 = hits; pulse_flag(7'h28); quiet(30);
    cmd(intc_pkg::CMD_RIM); wait_entry(vec_of(intc_pkg::SRC_TIMER));
    apb(1'b1, FLG, 32'h0000_0020);
    h0 = hits; cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_entry(vec_of(intc_pkg::SRC_SERIAL));
    apb(1'b1, FLG, 32'h0000_0000); cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_mask(1'b0);
    apb(1'b1, PEN, 32'h0000_0000); pulse_flag(7'h08);
    apb(1'b0, FLG, 32'h0000_0000); chk(rd, 32'h0000_0008);
    acc <= 7'h08; @(posedge sys_clk); acc <= 7'h00;
    h0 = hits; apb(1'b1, PEN, 32'h0000_0008); quiet(30);
    cmd(intc_pkg::CMD_SIM); wait_mask(1'b1);
    h0 = hits; cmd(intc_pkg::CMD_WFI); wait_mask(1'b0);
    chk({31'd0, hold}, 32'h0000_0001);
    n = 0; off = 0;
    repeat (6) begin @(negedge sys_clk); n += int'(pclk === 1'b1); off += int'(cpu_en !== 1'b0); end
    @(posedge sys_clk);
    chk(32'(n), 32'(6 / intc_pkg::OSC_DIV)); chk(32'(off), 32'h0000_0000);
    pulse_flag(7'h08); wait_entry(vec_of(intc_pkg::SRC_TIMER));
    apb(1'b1, FLG, 32'h0000_0000); cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_mask(1'b0);
    apb(1'b1, EXT, 32'h0000_0001); cmd(intc_pkg::CMD_SIM); wait_mask(1'b1);
    cmd(intc_pkg::CMD_HALT); wait_mask(1'b0);
    chk({31'd0, osc}, 32'h0000_0000);
    h0 = hits; pulse_flag(7'h08); quiet(30);
    chk({31'd0, osc}, 32'h0000_0000);
    pins[0] <= 1'b1; wait_entry(vec_of(intc_pkg::SRC_EXT));
    chk({31'd0, wc >= STAB + intc_pkg::CONTEXT_BYTES + 2}, 32'h0000_0001);
    apb(1'b1, FLG, 32'h0000_0000); cmd(intc_pkg::CMD_INTERRUPT_RETURN); wait_mask(1'b0);
    gap; chk(32'(g), 32'(intc_pkg::OSC_DIV));
    apb(1'b1, intc_pkg::CTRL_REG_ADDR, 32'h0000_0001); gap; gap;
    chk(32'(g), 32'(intc_pkg::OSC_DIV * intc_pkg::SLOW_DIV));
    wrap_up;
  end
endmodule // intc_pm_bench
